// ==== pfs_sequencer.sv ====
// Paper feed sequencer: tray lift, drawer and bypass feeding, clutch drive.
// Assumes an AHB-Lite master on CLK_SYS and raw sensor pins from the paper path.
//
// Contract
// - Speed request maps to transport clutch combination
// - Power-on: raise upper tray until tray-up
// - Stopped tray: sample empty sensor, low means empty
// - Raised tray stays raised, paper or not
// - Then raise lower tray in reverse, same check
// - Raise a drawer only once fully inserted
// - Paper on path at power-on: jam, block feeding
// - Ready only after raise and check; trays stay up
// - Drawer inserted or removed in ready: raise, recheck
// - Bypass: solenoid on, then bypass feed clutch
// - Registration hit: clutch off, solenoid off, registration on
// - Bypass tray empty drops the pickup solenoid
// - Bypass paper outranks drawer feeding
// - Lower feed: feed clutch plus upper, lower transport
// - Second transport sensor releases lower feed clutch
// - Registration hit releases upper and lower transport
// - Lower finish: registration plus middle transport clutches
// - Upper feed: feed clutch, registration stops, then registration
// - Run motor: high-side high, low-side low; lower tray's reverse run drives high-side low, low-side high
// - Brake motor: both control outputs high
// - Idle motor: both control outputs low
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pfs_sequencer #(
   parameter int BRAKE_CYC = pfs_pkg::BRAKE_CYC,
   parameter int ALIGN_CYC = pfs_pkg::ALIGN_CYC,
   parameter int DEB_CYC   = pfs_pkg::DEB_CYC
) (
   input  wire logic          CLK_SYS,
   input  wire logic          RST_N,
   input  wire logic          HSEL,
   input  wire logic [31:0]   HADDR,
   input  wire logic [1:0]    HTRANS,
   input  wire logic          HWRITE,
   input  wire logic [2:0]    HSIZE,
   input  wire logic [31:0]   HWDATA,
   input  wire logic          HREADY,
   output logic      [31:0]   HRDATA,
   output logic               HREADYOUT,
   output logic               HRESP,
   input  wire pfs_pkg::pfs_sens_type SENS,
   output pfs_pkg::pfs_act_type       ACT,
   output logic               TRAY_MOTOR_CTL_HI_PORT,
   output logic               TRAY_MOTOR_CTL_LO_PORT
);
   import pfs_pkg::*;

   typedef enum logic [3:0] {
      ST_SETTLE,
      ST_READY,
      ST_RAISE_UP,
      ST_BRAKE_UP,
      ST_RAISE_LO,
      ST_BRAKE_LO,
      ST_BP_SOL,
      ST_BP_FEED,
      ST_BP_REL,
      ST_BP_SOLOFF,
      ST_LD_FEED,
      ST_LD_TR,
      ST_DR_ALIGN,
      ST_UD_FEED,
      ST_REG_OUT
   } pfs_st_type;

   typedef struct packed {
      pfs_st_type        st;
      logic [TIME_W-1:0] tmr;
      logic              up_pend;
      logic              lo_pend;
      logic              up_empty;
      logic              lo_empty;
      logic              ins_up_d;
      logic              ins_lo_d;
      logic              jam;
      logic              feed_lower;
      logic [1:0]        speed;
      pfs_act_type       act;
      pfs_mot_type       mot;
      logic              ahb_wr;
      logic [ADDR_W-1:0] ahb_addr;
      logic [31:0]       rdata;
      logic              readyout;
   } pfs_state_type;

   pfs_state_type r_reg;
   pfs_state_type r_next;
   pfs_sens_type  s;
   logic [SENS_W-1:0] sens_clean;

   generate
      if (BRAKE_CYC < 1 || BRAKE_CYC >= 2 ** TIME_W ||
          ALIGN_CYC < 1 || ALIGN_CYC >= 2 ** TIME_W ||
          DEB_CYC < 1 || DEB_CYC + 4 >= 2 ** TIME_W) begin : g_bad
         $error("Timing parameters out of range for the timer width");
      end
   endgenerate

   genvar gi;
   generate
      for (gi = 0; gi < SENS_W; gi++) begin : g_deb
         pfs_debounce #(
            .DEB_CYC (DEB_CYC)
         ) u_deb (
            .CLK_SYS (CLK_SYS),
            .RST_N   (RST_N),
            .raw     (SENS[gi]),
            .clean   (sens_clean[gi])
         );
      end
   endgenerate

   assign s = pfs_sens_type'(sens_clean);

   always_comb begin
      logic       start;
      logic       want_lower;
      logic       path_busy;
      logic       ready_now;
      logic [31:0] stat;

      r_next     = r_reg;
      stat       = '0;
      start      = 1'b0;
      want_lower = r_reg.feed_lower;
      path_busy  = s.feed_sens | s.tr1_sens | s.tr2_sens | s.reg_sens;
      ready_now  = (r_reg.st == ST_READY) &&
                   !(r_reg.up_pend && s.ins_upper) &&
                   !(r_reg.lo_pend && s.ins_lower);

      if (r_reg.tmr != '0) begin
         r_next.tmr = r_reg.tmr - 1'b1;
      end

      // Bus data phase: writes land one cycle after the address phase
      if (r_reg.ahb_wr && r_reg.ahb_addr == CTRL_OFS) begin
         start        = HWDATA[CTRL_START_BIT];
         want_lower   = HWDATA[CTRL_LOWER_BIT];
         r_next.speed = HWDATA[CTRL_SPD_LSB +: 2];
      end

      // Drawer insertion or removal asks for a fresh raise and check
      if (r_reg.st != ST_SETTLE) begin
         r_next.ins_up_d = s.ins_upper;
         r_next.ins_lo_d = s.ins_lower;
         if (s.ins_upper != r_reg.ins_up_d) begin
            r_next.up_pend = 1'b1;
         end
         if (s.ins_lower != r_reg.ins_lo_d) begin
            r_next.lo_pend = 1'b1;
         end
         if (!s.ins_upper) begin
            r_next.up_empty = 1'b1;
         end
         if (!s.ins_lower) begin
            r_next.lo_empty = 1'b1;
         end
         // Jam clears only once the whole path reads clear
         if (!path_busy) begin
            r_next.jam = 1'b0;
         end
      end

      case (r_reg.st)
         ST_SETTLE: begin
            // Debouncers need a full window before their outputs mean anything
            if (r_reg.tmr == '0) begin
               r_next.jam      = path_busy;
               r_next.ins_up_d = s.ins_upper;
               r_next.ins_lo_d = s.ins_lower;
               r_next.st       = ST_READY;
            end
         end
         ST_READY: begin
            if (r_reg.up_pend && s.ins_upper) begin
               r_next.st = ST_RAISE_UP;
            end else if (r_reg.lo_pend && s.ins_lower) begin
               r_next.st = ST_RAISE_LO;
            end else if (start && !r_reg.jam) begin
               r_next.feed_lower = want_lower;
               if (s.bypass_paper) begin
                  r_next.feed_lower = 1'b0;
                  r_next.st         = ST_BP_SOL;
                  r_next.tmr        = TIME_W'(ALIGN_CYC);
               end else if (want_lower && s.ins_lower && !r_reg.lo_empty) begin
                  r_next.st = ST_LD_FEED;
               end else if (!want_lower && s.ins_upper && !r_reg.up_empty) begin
                  r_next.st = ST_UD_FEED;
               end
            end
         end
         ST_RAISE_UP: begin
            // Removal mid-raise stops the motor too
            if (s.tray_up_upper || !s.ins_upper) begin
               r_next.st  = ST_BRAKE_UP;
               r_next.tmr = TIME_W'(BRAKE_CYC);
            end
         end
         ST_BRAKE_UP: begin
            if (r_reg.tmr == '0) begin
               r_next.up_pend  = 1'b0;
               r_next.up_empty = !(s.empty_upper && s.ins_upper);
               r_next.st       = ST_READY;
            end
         end
         ST_RAISE_LO: begin
            if (s.tray_up_lower || !s.ins_lower) begin
               r_next.st  = ST_BRAKE_LO;
               r_next.tmr = TIME_W'(BRAKE_CYC);
            end
         end
         ST_BRAKE_LO: begin
            if (r_reg.tmr == '0) begin
               r_next.lo_pend  = 1'b0;
               r_next.lo_empty = !(s.empty_lower && s.ins_lower);
               r_next.st       = ST_READY;
            end
         end
         ST_BP_SOL: begin
            // Let the pickup arm drop before the roller turns
            if (r_reg.tmr == '0) begin
               r_next.st = ST_BP_FEED;
            end
         end
         ST_BP_FEED: begin
            if (s.reg_sens) begin
               r_next.st  = ST_BP_REL;
               r_next.tmr = TIME_W'(ALIGN_CYC);
            end
         end
         ST_BP_REL: begin
            if (r_reg.tmr == '0) begin
               r_next.st  = ST_BP_SOLOFF;
               r_next.tmr = TIME_W'(ALIGN_CYC);
            end
         end
         ST_BP_SOLOFF: begin
            if (r_reg.tmr == '0) begin
               r_next.st = ST_REG_OUT;
            end
         end
         ST_LD_FEED: begin
            if (s.tr2_sens) begin
               r_next.st = ST_LD_TR;
            end
         end
         ST_LD_TR: begin
            if (s.reg_sens) begin
               r_next.st  = ST_DR_ALIGN;
               r_next.tmr = TIME_W'(ALIGN_CYC);
            end
         end
         ST_UD_FEED: begin
            if (s.reg_sens) begin
               r_next.st  = ST_DR_ALIGN;
               r_next.tmr = TIME_W'(ALIGN_CYC);
            end
         end
         ST_DR_ALIGN: begin
            // Sheet buckles against the stopped rollers to square its edge
            if (r_reg.tmr == '0) begin
               r_next.st = ST_REG_OUT;
            end
         end
         ST_REG_OUT: begin
            if (!s.reg_sens) begin
               r_next.st = ST_READY;
            end
         end
         default: begin
            r_next.st = ST_SETTLE;
         end
      endcase

      // Actuators follow the next state so they leave straight from flops
      r_next.act = '0;
      r_next.mot = MOT_IDLE;
      case (r_next.st)
         ST_READY: begin
            case (r_next.speed)
               SPD_SLOW_SLOW: r_next.act.middle_transport_clutch = 1'b1;
               SPD_SLOW_FAST: begin
                  r_next.act.middle_transport_clutch = 1'b1;
                  r_next.act.lower_transport_clutch  = 1'b1;
               end
               SPD_FAST_FAST: r_next.act.upper_transport_clutch = 1'b1;
               default: r_next.act.upper_transport_clutch = 1'b0;
            endcase
         end
         ST_RAISE_UP: r_next.mot = MOT_FWD;
         ST_RAISE_LO: r_next.mot = MOT_REV;
         ST_BRAKE_UP: r_next.mot = MOT_BRAKE;
         ST_BRAKE_LO: r_next.mot = MOT_BRAKE;
         ST_BP_SOL: r_next.act.bypass_pickup_sol = 1'b1;
         ST_BP_FEED: begin
            r_next.act.bypass_pickup_sol  = 1'b1;
            r_next.act.bypass_feed_clutch = 1'b1;
         end
         ST_BP_REL: r_next.act.bypass_pickup_sol = 1'b1;
         ST_LD_FEED: begin
            r_next.act.lower_feed_clutch      = 1'b1;
            r_next.act.upper_transport_clutch = 1'b1;
            r_next.act.lower_transport_clutch = 1'b1;
         end
         ST_LD_TR: begin
            r_next.act.upper_transport_clutch = 1'b1;
            r_next.act.lower_transport_clutch = 1'b1;
         end
         ST_UD_FEED: r_next.act.upper_feed_clutch = 1'b1;
         ST_REG_OUT: begin
            r_next.act.reg_clutch              = 1'b1;
            r_next.act.middle_transport_clutch = r_next.feed_lower;
         end
         default: r_next.act = '0;
      endcase
      // Solenoid never stays down over an empty bypass tray
      if (!s.bypass_paper) begin
         r_next.act.bypass_pickup_sol = 1'b0;
      end

      // Status word, sampled in the address phase
      stat[STAT_READY_BIT]  = ready_now;
      stat[STAT_JAM_BIT]    = r_reg.jam;
      stat[STAT_UEMPT_BIT]  = r_reg.up_empty;
      stat[STAT_LEMPT_BIT]  = r_reg.lo_empty;
      stat[STAT_BUSY_BIT]   = (r_reg.st != ST_READY);
      stat[STAT_UINS_BIT]   = s.ins_upper;
      stat[STAT_LINS_BIT]   = s.ins_lower;

      r_next.readyout = 1'b1;
      r_next.ahb_wr   = 1'b0;
      r_next.rdata    = '0;
      if (HSEL && HREADY && HTRANS[1]) begin
         r_next.ahb_wr   = HWRITE;
         r_next.ahb_addr = HADDR[ADDR_W-1:0];
         if (!HWRITE) begin
            if (HADDR[ADDR_W-1:0] == CTRL_OFS) begin
               r_next.rdata[CTRL_LOWER_BIT]    = r_reg.feed_lower;
               r_next.rdata[CTRL_SPD_LSB +: 2] = r_reg.speed;
            end else if (HADDR[ADDR_W-1:0] == STAT_OFS) begin
               r_next.rdata = stat;
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         r_reg          <= '0;
         r_reg.st       <= ST_SETTLE;
         r_reg.tmr      <= TIME_W'(DEB_CYC + 4);
         r_reg.up_pend  <= 1'b1;
         r_reg.lo_pend  <= 1'b1;
         r_reg.up_empty <= 1'b1;
         r_reg.lo_empty <= 1'b1;
         r_reg.readyout <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign HRDATA                 = r_reg.rdata;
   assign HREADYOUT              = r_reg.readyout;
   assign HRESP                  = HRESP_OKAY;
   assign ACT                    = r_reg.act;
   assign TRAY_MOTOR_CTL_HI_PORT = r_reg.mot.tray_motor_cmd_one;
   assign TRAY_MOTOR_CTL_LO_PORT = r_reg.mot.tray_motor_cmd_zero;

endmodule

// ==== pfs_pkg.sv ====
// Shared constants and carrier types for the paper feed sequencer.
// Assumes a 200 MHz system clock and an AHB-Lite register slave.
package pfs_pkg;

   // Clock and timing, times in microseconds
   localparam int CLK_MHZ       = 200;
   localparam int BRAKE_TIME_US = 10000;
   localparam int ALIGN_TIME_US = 10000;
   localparam int DEB_TIME_US   = 1000;
   localparam int BRAKE_CYC     = BRAKE_TIME_US * CLK_MHZ;
   localparam int ALIGN_CYC     = ALIGN_TIME_US * CLK_MHZ;
   localparam int DEB_CYC       = DEB_TIME_US * CLK_MHZ;
   localparam int TIME_W        = 22;

   // Register map, byte addresses
   localparam int             ADDR_W     = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

   // Control register fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_LOWER_BIT = 1;
   localparam int CTRL_SPD_LSB   = 2;

   // Status register fields
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_JAM_BIT   = 1;
   localparam int STAT_UEMPT_BIT = 2;
   localparam int STAT_LEMPT_BIT = 3;
   localparam int STAT_BUSY_BIT  = 4;
   localparam int STAT_UINS_BIT  = 5;
   localparam int STAT_LINS_BIT  = 6;

   // Transport roller speed request codes (first roller, second roller)
   localparam logic [1:0] SPD_STOP      = 2'h0;
   localparam logic [1:0] SPD_SLOW_SLOW = 2'h1;
   localparam logic [1:0] SPD_SLOW_FAST = 2'h2;
   localparam logic [1:0] SPD_FAST_FAST = 2'h3;

   localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h1;
   localparam logic       HRESP_OKAY        = 1'b0;

   // Sensor pins, active high except the empty sensors, which read low when the tray is empty
   typedef struct packed {
      logic tray_up_upper;
      logic empty_upper;
      logic tray_up_lower;
      logic empty_lower;
      logic ins_upper;
      logic ins_lower;
      logic bypass_paper;
      logic reg_sens;
      logic tr1_sens;
      logic tr2_sens;
      logic feed_sens;
   } pfs_sens_type;

   localparam int SENS_W = $bits(pfs_sens_type);

   // Clutch and solenoid drives, all active high
   typedef struct packed {
      logic upper_transport_clutch;
      logic middle_transport_clutch;
      logic lower_transport_clutch;
      logic reg_clutch;
      logic bypass_feed_clutch;
      logic bypass_pickup_sol;
      logic upper_feed_clutch;
      logic lower_feed_clutch;
   } pfs_act_type;

   // Two-input tray motor driver command
   typedef struct packed {
      logic tray_motor_cmd_one;
      logic tray_motor_cmd_zero;
   } pfs_mot_type;

   localparam pfs_mot_type MOT_IDLE  = 2'h0;
   localparam pfs_mot_type MOT_FWD   = 2'h2;
   localparam pfs_mot_type MOT_REV   = 2'h1;
   localparam pfs_mot_type MOT_BRAKE = 2'h3;

endpackage

// ==== pfs_debounce.sv ====
// Two-stage synchroniser followed by a stability counter for one sensor.
// Assumes the raw input is asynchronous to CLK_SYS.
`timescale 1ns/1ps
module pfs_debounce #(
   parameter int DEB_CYC = pfs_pkg::DEB_CYC,
   parameter int CNT_W   = $clog2(DEB_CYC + 1)
) (
   input  wire logic CLK_SYS,
   input  wire logic RST_N,
   input  wire logic raw,
   output logic      clean
);
   import pfs_pkg::*;

   typedef struct packed {
      logic             s1;
      logic             s2;
      logic             clean;
      logic [CNT_W-1:0] cnt;
   } pfs_deb_state_type;

   pfs_deb_state_type r_reg;
   pfs_deb_state_type r_next;

   generate
      if (DEB_CYC < 1) begin : g_bad
         $error("DEB_CYC must be at least one");
      end
   endgenerate

   always_comb begin
      r_next    = r_reg;
      r_next.s1 = raw;
      r_next.s2 = r_reg.s1;
      // A level must hold for the full window before it is believed
      if (r_reg.s2 != r_reg.clean) begin
         if (r_reg.cnt == CNT_W'(DEB_CYC - 1)) begin
            r_next.clean = r_reg.s2;
            r_next.cnt   = '0;
         end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
         end
      end else begin
         r_next.cnt = '0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign clean = r_reg.clean;

endmodule

// ==== pfs_sequencer_asserts.sv ====
// Port-level checker for the paper feed sequencer.
// Assumes binding to pfs_sequencer with its debounce parameter handed on.
`timescale 1ns/1ps
module pfs_sequencer_asserts
   import pfs_pkg::*;
#(
   parameter int DEB_CYC = pfs_pkg::DEB_CYC
) (
   input wire logic                  CLK_SYS,
   input wire logic                  RST_N,
   input wire logic                  HSEL,
   input wire logic [1:0]            HTRANS,
   input wire logic                  HREADY,
   input wire logic [31:0]           HRDATA,
   input wire logic                  HREADYOUT,
   input wire logic                  HRESP,
   input wire pfs_pkg::pfs_sens_type SENS,
   input wire pfs_pkg::pfs_act_type  ACT,
   input wire logic                  TRAY_MOTOR_CTL_HI_PORT,
   input wire logic                  TRAY_MOTOR_CTL_LO_PORT
);
   wire logic hi = TRAY_MOTOR_CTL_HI_PORT;
   wire logic lo = TRAY_MOTOR_CTL_LO_PORT;
   int        up_n;
   int        low_n;
   int        bp_n;

   // Run lengths of settled sensor levels; margin covers the debounce latency
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         up_n  <= 0;
         low_n <= 0;
         bp_n  <= 0;
      end else begin
         up_n  <= SENS.tray_up_upper ? up_n + 1 : 0;
         low_n <= SENS.tray_up_lower ? low_n + 1 : 0;
         bp_n  <= SENS.bypass_paper ? 0 : bp_n + 1;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   a_bus_okay_ready: assert property (HREADYOUT && !HRESP)
      else $error("bus slave stalled or answered with an error");
   a_rdata_idle_zero: assert property (!(HSEL && HREADY && HTRANS[1]) |=> HRDATA == 32'h0)
      else $error("read data present outside a data phase");
   a_upper_raise_stop: assert property (up_n >= DEB_CYC + 6 |-> !(hi && !lo))
      else $error("motor still raising with upper tray up");
   a_lower_raise_stop: assert property (low_n >= DEB_CYC + 6 |-> !(!hi && lo))
      else $error("motor still raising with lower tray up");
   a_run_ends_brake: assert property ($fell(hi ^ lo) |-> hi && lo)
      else $error("motor run not ended by braking");
   a_brake_then_idle: assert property ($rose(hi && lo) |-> ##[1:40] (!hi && !lo))
      else $error("motor brake not followed by idle");
   a_pickup_drop: assert property (bp_n >= DEB_CYC + 8 |-> !ACT.bypass_pickup_sol)
      else $error("pickup solenoid on with bypass tray empty");
   a_bypass_sol_first: assert property ($rose(ACT.bypass_feed_clutch)
      |-> $past(ACT.bypass_pickup_sol))
      else $error("bypass clutch engaged before solenoid");
   a_lower_transport: assert property (ACT.lower_feed_clutch |-> ACT.upper_transport_clutch
      && ACT.lower_transport_clutch && !ACT.middle_transport_clutch)
      else $error("lower feed without its transport clutches");
   a_reg_alone: assert property ($rose(ACT.reg_clutch) |-> !(ACT.bypass_feed_clutch
      || ACT.upper_feed_clutch || ACT.lower_feed_clutch || ACT.bypass_pickup_sol))
      else $error("registration engaged before feed released");
endmodule

bind pfs_sequencer pfs_sequencer_asserts #(.DEB_CYC(DEB_CYC)) pfs_sequencer_asserts_i (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS), .HREADY(HREADY),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SENS(SENS), .ACT(ACT),
   .TRAY_MOTOR_CTL_HI_PORT(TRAY_MOTOR_CTL_HI_PORT),
   .TRAY_MOTOR_CTL_LO_PORT(TRAY_MOTOR_CTL_LO_PORT));

// ==== pfs_paper_path.sv ====
// Behavioural paper path: trays, sheet travel and sensors.
// Assumes the bench sets drawers, paper stock and a stuck sheet directly.
`timescale 1ns/1ps
module pfs_paper_path
   import pfs_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire pfs_pkg::pfs_act_type act,
   input  wire logic                 mot_first,
   input  wire logic                 mot_second,
   input  wire logic                 ins_upper,
   input  wire logic                 ins_lower,
   input  wire logic                 paper_upper,
   input  wire logic                 paper_lower,
   input  wire logic                 bypass_paper,
   input  wire logic                 jam,
   output pfs_pkg::pfs_sens_type     sens
);
   int   up_h;
   int   lo_h;
   int   pos;
   int   out_n;
   logic low_sheet;
   wire logic moving = act.upper_feed_clutch | act.lower_feed_clutch | act.bypass_feed_clutch
      | act.upper_transport_clutch | act.lower_transport_clutch;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_h <= 0;
         lo_h <= 0;
         pos <= 0;
         out_n <= 0;
         low_sheet <= 1'b0;
      end else begin
         // First high, second low turns clockwise; the reverse turns counter-clockwise
         up_h <= !ins_upper ? 0 : (mot_first && !mot_second && up_h < 20) ? up_h + 1 : up_h;
         lo_h <= !ins_lower ? 0 : (!mot_first && mot_second && lo_h < 20) ? lo_h + 1 : lo_h;
         if (act.lower_feed_clutch)
            low_sheet <= 1'b1;
         if (act.reg_clutch && pos >= 40) begin
            out_n <= out_n + 1;
            if (out_n == 20) begin
               pos <= 0;
               out_n <= 0;
               low_sheet <= 1'b0;
            end
         end else if (moving && pos < 40)
            pos <= pos + 1;
      end
   end

   // A removed drawer drops its tray, so its sensors read low
   assign sens = '{tray_up_upper: up_h == 20, empty_upper: ins_upper & paper_upper,
      tray_up_lower: lo_h == 20, empty_lower: ins_lower & paper_lower, ins_upper: ins_upper,
      ins_lower: ins_lower, bypass_paper: bypass_paper, reg_sens: pos >= 40,
      tr1_sens: pos >= 30, tr2_sens: low_sheet && pos >= 20, feed_sens: jam};
endmodule

// ==== pfs_sequencer_tb_top.sv ====
// Self-checking bench: bus tasks plus pin waits on the actuator outputs.
// Assumes shortened debounce, brake and align counts on the design.
`timescale 1ns/1ps
module pfs_sequencer_tb_top;
   import pfs_pkg::*;
   logic         clk_sys = 1'b0;
   logic         rst_n = 1'b0;
   logic         hsel = 1'b0;
   logic [31:0]  haddr = 32'h0;
   logic [1:0]   htrans = 2'h0;
   logic         hwrite = 1'b0;
   logic [31:0]  hwdata = 32'h0;
   logic [31:0]  hrdata;
   logic [31:0]  hrdata_q;
   logic         hreadyout;
   logic         hresp;
   logic         mot_hi;
   logic         mot_lo;
   pfs_sens_type sens;
   pfs_act_type  act;
   logic         ins_u = 1'b1, ins_l = 1'b0, pap_u = 1'b1, pap_l = 1'b0, bp = 1'b0, jam = 1'b1;
   logic [31:0]  rd;
   int           bad_count = 0;
   int           checked = 0;
   wire  [9:0]   pins = {act, mot_hi, mot_lo};

   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) hrdata_q <= hrdata;

   pfs_sequencer #(.BRAKE_CYC(8), .ALIGN_CYC(8), .DEB_CYC(4)) pfs_sequencer_i (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .SENS(sens), .ACT(act),
      .TRAY_MOTOR_CTL_HI_PORT(mot_hi), .TRAY_MOTOR_CTL_LO_PORT(mot_lo));

   pfs_paper_path pfs_paper_path_i (.clk(clk_sys), .rst_n(rst_n), .act(act), .mot_first(mot_hi),
      .mot_second(mot_lo), .ins_upper(ins_u), .ins_lower(ins_l), .paper_upper(pap_u),
      .paper_lower(pap_l), .bypass_paper(bp), .jam(jam), .sens(sens));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      #1 rd = hrdata_q;
   endtask

   // Pins are looked at on the falling edge, clear of the design's updates
   task automatic wait_for(input logic [9:0] mask, input logic [9:0] exp);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while ((pins & mask) !== exp && n < 400);
      chk({22'h0, pins & mask}, {22'h0, exp});
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         xfer(1'b0, STAT_OFS, 32'h0);
         n++;
      end while (rd[STAT_READY_BIT] !== 1'b1 && n < 200);
   endtask

   task automatic act_seq(input logic [7:0] a0, a1, a2, a3, a4);
      wait_for(10'h3FC, {a0, 2'b00});
      wait_for(10'h3FC, {a1, 2'b00});
      wait_for(10'h3FC, {a2, 2'b00});
      wait_for(10'h3FC, {a3, 2'b00});
      wait_for(10'h3FC, {a4, 2'b00});
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk({24'h0, act}, 32'h0);
      wait_for(10'h003, 10'h002);
      wait_for(10'h003, 10'h003);
      wait_for(10'h003, 10'h000);
      wait_ready();
      chk(rd, 32'h2B);
      chk({30'h0, mot_hi, mot_lo}, 32'h0);
      xfer(1'b1, CTRL_OFS, 32'h1);
      repeat (30) @(posedge clk_sys);
      chk({24'h0, act}, 32'h0);
      jam <= 1'b0;
      pap_l <= 1'b1;
      ins_l <= 1'b1;
      wait_for(10'h003, 10'h001);
      wait_for(10'h003, 10'h003);
      wait_for(10'h003, 10'h000);
      wait_ready();
      chk(rd, 32'h61);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, CTRL_OFS, 32'(i) << CTRL_SPD_LSB);
         repeat (3) @(negedge clk_sys);
         chk({29'h0, act[7:5]}, (i == 0) ? 32'h0 : (i == 1) ? 32'h2 : (i == 2) ? 32'h3 : 32'h4);
      end
      xfer(1'b1, CTRL_OFS, 32'h1);
      act_seq(8'h02, 8'h00, 8'h10, 8'h00, 8'h00);
      wait_ready();
      xfer(1'b1, CTRL_OFS, 32'h3);
      act_seq(8'hA1, 8'hA0, 8'h00, 8'h50, 8'h00);
      wait_ready();
      bp <= 1'b1;
      repeat (12) @(posedge clk_sys);
      xfer(1'b1, CTRL_OFS, 32'h3);
      act_seq(8'h04, 8'h0C, 8'h04, 8'h00, 8'h10);
      wait_for(10'h3FC, 10'h000);
      wait_ready();
      xfer(1'b1, CTRL_OFS, 32'h1);
      wait_for(10'h3FC, 10'h030);
      wait_for(10'h3FC, 10'h010);
      // Tray emptied while the solenoid is still down: it must lift early
      bp <= 1'b0;
      repeat (8) @(negedge clk_sys);
      chk({24'h0, act}, 32'h0);
      wait_ready();
      xfer(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      report_and_stop();
   end
endmodule
